// *** scs_modem_model.sv ***
// modem line partner that toggles its control pins on request
`timescale 1ns/10ps
module scs_modem_model (
  input  wire logic           aclk,
  input  wire logic [3:0]     flip,
  output scs_pkg::scs_modem_t pins
);
  // mixed start levels so both edge directions are exercised
  initial pins = 4'h5;
  always @(posedge aclk) pins <= pins ^ flip;
endmodule

// *** scs_pkg.sv ***
// constants and carriers for the serial channel low status bits
package scs_pkg;
  localparam logic [3:0]  STATUS_OFS  = 4'h0;
  localparam logic [3:0]  CTRL_OFS    = 4'h4;
  localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam int          B_RX_DATA_READY_PENDING      = 11;
  localparam int          B_RBC       = 9;
  localparam int          B_RX_FIFO_FULL_FLAG     = 8;
  localparam int          B_DCD       = 7;
  localparam int          B_RI        = 6;
  localparam int          B_DSR       = 5;
  localparam int          B_CTS       = 4;
  localparam int          B_TX_SPACE_READY_PENDING      = 3;
  localparam int          B_TX_FIFO_HALF_EMPTY_PENDING     = 2;
  localparam int          B_TBC       = 1;
  localparam int          B_TEMPTY    = 0;
  localparam int          B_RXST_LO   = 26;
  localparam int          RXST_W      = 6;
  localparam int          C_RXDMA     = 16;
  localparam int          C_TXDMA     = 17;
  localparam logic [31:0] IE_MASK     = 32'h0000_0efe;
  localparam logic [31:0] W1C_MASK    = 32'h0000_02f2;
  localparam logic [31:0] CTRL_MASK   = 32'h0003_0efe;
  localparam int          TX_FIFO_HALF_EMPTY_PENDING_BYTES = 16;
  localparam logic [1:0]  ARM_DONE    = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } scs_modem_t;

  typedef struct packed {
    logic              close;
    logic [RXST_W-1:0] status;
    logic              avail;
    logic              full;
  } scs_rx_t;

  typedef struct packed {
    logic empty;
    logic shift_idle;
  } scs_tx_t;
endpackage

// *** scs_status.sv ***
// low status bits of a serial channel with an axi4-lite register slave
// Functional notes
// - receive-closed flag bit 9 sets on buffer close, clears on write-one
// - in receive dma mode the receive-closed flag clears itself
// - bits 31:26 hold the closed buffer's status while receive-closed is set
// - receive-ready is held low while receive-closed is set
// - dma mode writes status to descriptor; interlock is in hardware
// - flags in bits 11:9 and 7:1 raise interrupt only when their enable bit is set; bits 8 and 0 never raise it
// - bit 8 shows receive fifo full at each read
// - bit 7 latches on any carrier-detect change, cleared by write-one
// - bit 6 latches on any ring-indicator change, cleared by write-one
// - bit 5 latches on any data-set-ready change, cleared by write-one
// - bit 4 latches on any clear-to-send change, cleared by write-one
// - bit 3 shows the transmit fifo can take more data
// - transmit-ready held low while transmit-closed is set
// - in transmit dma mode the transmit-closed interlock is in hardware
// - bit 2 shows transmit fifo has room for at least 16 bytes
// - receive-ready shows data waits in the receive fifo
// - transmit-closed sets when the fifo and shifter have both drained
`timescale 1ns/10ps
module scs_status #(
  parameter int AW  = 4,
  parameter int TCW = 6,
  parameter int THB = scs_pkg::TX_FIFO_HALF_EMPTY_PENDING_BYTES
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [AW-1:0]        awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [AW-1:0]        araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire scs_pkg::scs_modem_t  modem_in,
  input  wire scs_pkg::scs_rx_t     rx,
  input  wire scs_pkg::scs_tx_t     tx,
  input  wire logic [TCW-1:0]       tx_free,
  output logic                      desc_we,
  output logic [scs_pkg::RXST_W-1:0] desc_status,
  output logic                      channel_irq
);
  generate
    if (AW < 3 || THB < 1 || THB > (2**TCW) - 1) begin : g_bad
      $error("scs_status: parameter out of range");
    end
  endgenerate

  // axi4-lite write side
  logic          aw_have_ff;
  logic          w_have_ff;
  logic [AW-1:0] awaddr_ff;
  logic [31:0]   wdata_ff;
  logic [3:0]    wstrb_ff;
  logic          bvalid_ff;
  logic [1:0]    bresp_ff;
  logic          wr_go;
  logic          wr_stat;
  logic          wr_ctrl;
  logic [31:0]   bmask;

  assign awready = !aw_have_ff && !bvalid_ff;
  assign wready  = !w_have_ff && !bvalid_ff;
  assign wr_go   = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_stat = wr_go && awaddr_ff == AW'(scs_pkg::STATUS_OFS);
  assign wr_ctrl = wr_go && awaddr_ff == AW'(scs_pkg::CTRL_OFS);
  assign bmask   = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= awaddr;
      end else if (wr_go) begin
        aw_have_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= wdata;
        wstrb_ff  <= wstrb;
      end else if (wr_go) begin
        w_have_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= scs_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_stat || wr_ctrl) ? scs_pkg::RESP_OKAY : scs_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // control: interrupt enables and dma modes
  logic [31:0] ctrl_ff;
  logic        rx_dma;
  logic        tx_dma;

  assign rx_dma = ctrl_ff[scs_pkg::C_RXDMA];
  assign tx_dma = ctrl_ff[scs_pkg::C_TXDMA];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= scs_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= ((wdata_ff & bmask) | (ctrl_ff & ~bmask)) & scs_pkg::CTRL_MASK;
    end
  end

  // write-one acknowledge; zeros and read-only bits fall out of the mask
  logic [31:0] ack;
  assign ack = wr_stat ? (wdata_ff & bmask & scs_pkg::W1C_MASK) : '0;

  // modem lines come from pins: two flops, then a third for change detect
  scs_pkg::scs_modem_t msync1_ff;
  scs_pkg::scs_modem_t msync2_ff;
  scs_pkg::scs_modem_t mprev_ff;
  scs_pkg::scs_modem_t mchg_ff;
  logic [1:0]          arm_ff;
  logic [3:0]          mev;
  logic [3:0]          mack;

  // no change is reported until prev has caught the settled line level
  assign mev  = (arm_ff == scs_pkg::ARM_DONE) ? (msync2_ff ^ mprev_ff) : 4'h0;
  assign mack = ack[scs_pkg::B_DCD:scs_pkg::B_CTS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msync1_ff <= '0;
      msync2_ff <= '0;
      mprev_ff  <= '0;
      arm_ff    <= 2'h0;
    end else begin
      msync1_ff <= modem_in;
      msync2_ff <= msync1_ff;
      mprev_ff  <= msync2_ff;
      if (arm_ff != scs_pkg::ARM_DONE) begin
        arm_ff <= arm_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mchg_ff <= '0;
    end else begin
      mchg_ff <= mev | (mchg_ff & ~mack);
    end
  end

  // receive buffer closed and its status snapshot
  logic                       rbc_ff;
  logic [scs_pkg::RXST_W-1:0] rxst_ff;
  logic                       desc_we_ff;
  logic [scs_pkg::RXST_W-1:0] desc_st_ff;
  logic                       rbc_clr;

  // dma mode: the descriptor already has the status, so no one acknowledges
  assign rbc_clr = ack[scs_pkg::B_RBC] || rx_dma;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rbc_ff <= 1'b0;
    end else begin
      rbc_ff <= rx.close || (rbc_ff && !rbc_clr);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxst_ff <= '0;
    end else if (rx.close) begin
      rxst_ff <= rx.status;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      desc_we_ff <= 1'b0;
      desc_st_ff <= '0;
    end else begin
      desc_we_ff <= rx.close && rx_dma;
      if (rx.close && rx_dma) begin
        desc_st_ff <= rx.status;
      end
    end
  end

  assign desc_we     = desc_we_ff;
  assign desc_status = desc_st_ff;

  // transmit buffer closed on the drained edge of fifo plus shifter
  logic tdone_prev_ff;
  logic tbc_ff;
  logic tdone;

  assign tdone = tx.empty && tx.shift_idle;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // starts high: an idle, drained transmitter after reset is no close event
      tdone_prev_ff <= 1'b1;
      tbc_ff        <= 1'b0;
    end else begin
      tdone_prev_ff <= tdone;
      tbc_ff <= (tdone && !tdone_prev_ff) || (tbc_ff && !ack[scs_pkg::B_TBC] && !tx_dma);
    end
  end

  // status word as software sees it
  logic [31:0] stat;
  always_comb begin
    stat                    = scs_pkg::STATUS_RST;
    stat[31:26]             = rxst_ff;
    stat[scs_pkg::B_RX_DATA_READY_PENDING]   = rx.avail && !rbc_ff;
    stat[scs_pkg::B_RBC]    = rbc_ff;
    stat[scs_pkg::B_RX_FIFO_FULL_FLAG]  = rx.full;
    stat[scs_pkg::B_DCD]    = mchg_ff.dcd;
    stat[scs_pkg::B_RI]     = mchg_ff.ri;
    stat[scs_pkg::B_DSR]    = mchg_ff.dsr;
    stat[scs_pkg::B_CTS]    = mchg_ff.cts;
    stat[scs_pkg::B_TX_SPACE_READY_PENDING]   = tx_free != '0 && !tbc_ff;
    stat[scs_pkg::B_TX_FIFO_HALF_EMPTY_PENDING]  = tx_free >= TCW'(THB);
    stat[scs_pkg::B_TBC]    = tbc_ff;
    stat[scs_pkg::B_TEMPTY] = tx.empty;
  end

  logic irq_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(stat & ctrl_ff & scs_pkg::IE_MASK);
    end
  end
  assign channel_irq = irq_ff;

  // axi4-lite read side: one cycle from address to data
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  assign arready = !rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= scs_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      if (araddr == AW'(scs_pkg::STATUS_OFS)) begin
        rdata_ff <= stat;
        rresp_ff <= scs_pkg::RESP_OKAY;
      end else if (araddr == AW'(scs_pkg::CTRL_OFS)) begin
        rdata_ff <= ctrl_ff;
        rresp_ff <= scs_pkg::RESP_OKAY;
      end else begin
        rdata_ff <= '0;
        rresp_ff <= scs_pkg::RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rbc_ack_clear: assert property (
    rbc_ff && ack[scs_pkg::B_RBC] && !rx.close |=> !rbc_ff)
    else $error("receive-closed not cleared by acknowledge");
  a_rbc_hold: assert property (
    rbc_ff && !rbc_clr |=> rbc_ff)
    else $error("receive-closed dropped without acknowledge");
  a_rbc_dma_auto: assert property (
    rbc_ff && rx_dma && !rx.close |=> !rbc_ff)
    else $error("receive-closed not auto cleared in dma mode");
  a_rxst_snapshot: assert property (
    rx.close |=> rbc_ff && stat[31:26] == $past(rx.status))
    else $error("closed buffer status not held");
  a_rx_data_ready_pending_lock: assert property (
    rbc_ff |-> !stat[scs_pkg::B_RX_DATA_READY_PENDING])
    else $error("receive-ready active while receive-closed set");
  a_desc_write: assert property (
    rx.close && rx_dma |=> desc_we && desc_status == $past(rx.status))
    else $error("descriptor status not written");
  a_irq_gate: assert property (
    channel_irq |-> $past(|(stat & ctrl_ff & scs_pkg::IE_MASK)))
    else $error("interrupt without enabled flag");
  a_modem_latch: assert property (
    mev != 4'h0 |=> (mchg_ff & $past(mev)) == $past(mev))
    else $error("modem change not latched");
  a_tx_space_ready_pending_lock: assert property (
    tbc_ff |-> !stat[scs_pkg::B_TX_SPACE_READY_PENDING])
    else $error("transmit-ready active while transmit-closed set");
  a_tx_fifo_half_empty_pending_space: assert property (
    arvalid && arready && araddr == AW'(scs_pkg::STATUS_OFS) |=>
      rdata[scs_pkg::B_TX_FIFO_HALF_EMPTY_PENDING] == ($past(tx_free) >= TCW'(THB)))
    else $error("half-empty flag wrong");
  a_tbc_set: assert property (
    tdone && !tdone_prev_ff |=> tbc_ff)
    else $error("transmit-closed not set on drain");
  a_set_wins: assert property (
    rx.close && ack[scs_pkg::B_RBC] |=> rbc_ff)
    else $error("acknowledge beat a new close event");
  a_tbc_dma_auto: assert property (
    tbc_ff && tx_dma && !(tdone && !tdone_prev_ff) |=> !tbc_ff)
    else $error("transmit-closed not auto cleared in dma mode");
  a_sticky_keep: assert property (
    (mchg_ff & ~mack) != 4'h0 |=>
      (mchg_ff & $past(mchg_ff & ~mack)) == $past(mchg_ff & ~mack))
    else $error("sticky change flag lost without acknowledge");
endmodule

// *** scs_status_tb.sv ***
// self-checking bench for the serial channel low status bits
`timescale 1ns/10ps
module scs_status_tb;
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic [3:0]          awaddr, araddr, wstrb, flip;
  logic [31:0]         wdata, rdata, cap, seed;
  logic                awvalid, wvalid, bready, arvalid, rready;
  logic                awready, wready, bvalid, arready, rvalid, desc_we, channel_irq;
  logic [1:0]          bresp, rresp;
  logic [5:0]          desc_status, tx_free, v;
  scs_pkg::scs_rx_t    rx;
  scs_pkg::scs_tx_t    tx;
  scs_pkg::scs_modem_t pins;
  logic [65:0]         ent;
  logic [65:0]         q[$];
  logic [1:0]          bq[$];
  int                  bad_count = 0;
  int                  total_checks = 0;

  scs_status dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .modem_in(pins), .rx(rx), .tx(tx), .tx_free(tx_free), .desc_we(desc_we),
    .desc_status(desc_status), .channel_irq(channel_irq));
  scs_modem_model modem (.aclk(aclk), .flip(flip), .pins(pins));

  initial forever #12.5 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // rready and bready stay high, so the master always accepts answers
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] r);
    q.push_back({r, m, e});
    arvalid <= 1'b1;
    araddr  <= a;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    bq.push_back((a == 4'h0 || a == 4'h4) ? 2'h0 : 2'h2);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
  endtask

  task automatic close_rx(input logic [5:0] s);
    rx.status <= s;
    rx.close  <= 1'b1;
    @(posedge aclk);
    rx.close  <= 1'b0;
  endtask

  // response checker pops the oldest noted expectation
  always @(posedge aclk) begin
    if (rvalid && rready && q.size() != 0) begin
      ent = q.pop_front();
      check(rdata & ent[63:32], ent[31:0]);
      check({30'h0, rresp}, {30'h0, ent[65:64]});
    end
    if (bvalid && bready && bq.size() != 0) begin
      check({30'h0, bresp}, {30'h0, bq.pop_front()});
    end
  end

  initial begin
    #(25 * 4000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h7f4f7106;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb, flip} = '0;
    {rx, tx, tx_free} = '0;
    rready = 1'b1;
    bready = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(4);
    rd(4'h0, 32'hffff_ffff, 32'h0, 2'h0);
    rd(4'h4, 32'hffff_ffff, 32'h0, 2'h0);
    rd(4'h8, 32'hffff_ffff, 32'h0, 2'h2);
    rx.full  <= 1'b1;
    rx.avail <= 1'b1;
    cyc(2);
    rd(4'h0, 32'h0000_0b00, 32'h0000_0900, 2'h0);
    cap = $random(seed);
    close_rx(cap[5:0]);
    cyc(2);
    rd(4'h0, 32'hfc00_0a00, {cap[5:0], 26'h200}, 2'h0);
    check({31'h0, channel_irq}, 32'h0);
    // zero strobes and a zero in bit 9 must both leave the sticky flag alone
    wr(4'h0, 32'h0000_0200, 4'h0);
    wr(4'h0, 32'hffff_fdff, 4'hf);
    rd(4'h0, 32'h0000_0a00, 32'h0000_0200, 2'h0);
    wr(4'h0, 32'h0000_0200, 4'h2);
    rd(4'h0, 32'h0000_0a00, 32'h0000_0800, 2'h0);
    wr(4'h4, 32'h0000_0200, 4'hf);
    close_rx(6'h2a);
    cyc(3);
    check({31'h0, channel_irq}, 32'h1);
    wr(4'h0, 32'h0000_0200, 4'hf);
    cyc(2);
    check({31'h0, channel_irq}, 32'h0);
    wr(4'h4, 32'h0001_0000, 4'hf);
    cap = $random(seed);
    close_rx(cap[5:0]);
    v = cap[5:0];
    cap = 32'hx;
    repeat (4) begin
      @(posedge aclk);
      if (desc_we === 1'b1) cap = {26'h0, desc_status};
    end
    check(cap, {26'h0, v});
    rd(4'h0, 32'h0000_0a00, 32'h0000_0800, 2'h0);
    for (int j = 0; j < 8; j++) begin
      flip <= 4'h8 >> (j % 4);
      @(posedge aclk);
      flip <= 4'h0;
      cyc(6);
      rd(4'h0, 32'h0000_00f0, 32'h80 >> (j % 4), 2'h0);
      wr(4'h0, 32'h80 >> (j % 4), 4'h1);
    end
    rd(4'h0, 32'h0000_00f0, 32'h0, 2'h0);
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 6'd15 : (k == 1) ? 6'd16 : (k == 2) ? 6'd0 : 6'($random(seed));
      tx_free <= v;
      cyc(2);
      rd(4'h0, 32'hc, {28'h0, v != 6'd0, v >= 6'd16, 2'h0}, 2'h0);
    end
    tx_free       <= 6'd20;
    tx.empty      <= 1'b1;
    tx.shift_idle <= 1'b1;
    cyc(3);
    rd(4'h0, 32'hf, 32'h7, 2'h0);
    wr(4'h0, 32'h2, 4'h1);
    rd(4'h0, 32'hf, 32'hd, 2'h0);
    tx.empty <= 1'b0;
    wr(4'h4, 32'h0002_0000, 4'hf);
    tx.empty <= 1'b1;
    cyc(4);
    rd(4'h0, 32'hf, 32'hd, 2'h0);
    // unmapped write is refused, then a two-lane control write keeps lane 2
    wr(4'h8, 32'hffff_ffff, 4'hf);
    wr(4'h4, 32'hffff_ffff, 4'h3);
    rd(4'h4, 32'hffff_ffff, 32'h0002_0efe, 2'h0);
    cyc(2);
    check({31'h0, channel_irq}, 32'h1);
    cyc(4);
    check(32'(q.size() + bq.size()), 32'h0);
    tally_and_finish();
  end
endmodule
